/* capture_compare_mode_sync_shutdown.v */
// What this block does
// RULE_01 - Capture codes 1,2,3 capture on rising, falling, either edge.
// RULE_02 - Capture code 4 every fourth rise, code 5 every sixteenth rise.
// RULE_03 - Capture code 0 is edge detect on both edges; 011x, 1xxx reserved.
// RULE_04 - Compare code 1111 passes selected capture input as module output.
// RULE_05 - Code 0111 variable frequency, 0110 centre-aligned buffered on full variant.
// RULE_06 - Code 0100 dual edge unbuffered, 0101 dual edge buffered.
// RULE_07 - Single edge: 0001 sets, 0010 clears, 0011 toggles output on match.
// RULE_08 - Code 0000 plain timer, outputs off; 1110, 110x, 10xx reserved.
// RULE_09 - Postscale source bit picks trigger events or period events; capture ignores.
// RULE_10 - Retrigger while running only when retrigger bit set in triggered mode.
// RULE_11 - Interrupt once per N+1 period matches or captures.
// RULE_12 - Capture postscale above 1:4 overflows buffer; only up to 1:4 usable.
// RULE_13 - Trigger enable makes timer wait for sync source; else free running.
// RULE_14 - One-shot runs timer a limited number of periods per trigger.
// RULE_15 - Sync output is rollover event, or alternate signal when bit set.
// RULE_16 - Sync code 11111 means no sync; roll at period or all ones.
// RULE_17 - Five-bit sync select picks the reset or trigger source.
// RULE_18 - Auto-restart clears shutdown flag at next period once input gone.
// RULE_19 - Gate mode delays shutdown to next rollover, else immediate.
// RULE_20 - Software shutdown bit forces a shutdown honouring gate mode.
// RULE_21 - Eight enable bits select comparators, logic cell, fault A and B; the code ignores bits 3 and 4.
// RULE_22 - Capture select bit chooses capture when 1, compare/timer when 0.
// RULE_23 - Width bit selects 32-bit time base when 1, else 16-bit.
// RULE_24 - One-shot extension adds 0 to 7 extra periods.
// RULE_25 - Reserved codes produce no output activity and no captures.
// RULE_26 - Control bits reset to zero; unimplemented bits read zero.
//
// Implementation choices: register access over AXI4-Lite and the address map.
`include "ccp_ctrl_regs.vh"
module capture_compare_mode_sync_shutdown #(
	parameter FULL_VARIANT = 1
)(
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire [31:0] sync_sources,
	input  wire [7:0]  capture_inputs,
	input  wire [7:0]  shutdown_inputs,
	input  wire        alternate_sync,
	input  wire [31:0] compare_value,
	output reg         module_output,
	output reg         capture_event,
	output reg  [31:0] captured_value,
	output reg         sync_output,
	output reg         module_irq,
	output reg         shutdown_event_flag,
	output reg  [31:0] timer_value,
	output wire        timer_running
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg  [15:0] control_one_low;
	reg  [15:0] control_one_high;
	reg  [15:0] control_two_low;
	reg  [15:0] period_value;

	wire [3:0] function_code           = control_one_low[3:0];
	wire       capture_vs_compare      = control_one_low[`FLD_CAPSEL];
	wire       wide_timebase           = control_one_low[`FLD_WIDE];
	wire       postscale_event_source  = control_one_high[`FLD_PSSRC];
	wire       retrigger_allow         = control_one_high[`FLD_RETRIG];
	wire [3:0] irq_postscale           = control_one_high[11:8];
	wire       triggered_timebase_enable = control_one_high[`FLD_TRIGGERED_TIMEBASE_ENABLE];
	wire       single_pulse_trigger    = control_one_high[`FLD_SINGLE_PULSE_TRIGGER];
	wire       alternate_align_output  = control_one_high[`FLD_ALTERNATE_ALIGN_OUTPUT];
	wire [4:0] sync_select             = control_one_high[4:0];
	wire       auto_restart_after_shutdown = control_two_low[`FLD_AUTORST];
	wire       shutdown_wait_for_rollover  = control_two_low[`FLD_GATEMODE];
	wire       software_force_shutdown = control_two_low[`FLD_SWSHUT];
	wire [7:0] shutdown_source_enables = control_two_low[7:0];
	// Extension and input select live in spare upper bits of the period word
	reg  [2:0] one_shot_extension;
	reg  [2:0] capture_input_select;

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	reg         aw_held;
	reg         w_held;
	reg  [3:0]  aw_addr;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;
	wire        do_write = aw_held & w_held & ~s_axi_bvalid;
	wire [15:0] merged = {w_strb[1] ? w_data[15:8] : 8'h00, w_strb[0] ? w_data[7:0] : 8'h00};
	wire [15:0] keepmsk = {w_strb[1] ? 8'h00 : 8'hff, w_strb[0] ? 8'h00 : 8'hff};

	assign s_axi_awready = ~aw_held;
	assign s_axi_wready  = ~w_held;
	assign s_axi_arready = ~s_axi_rvalid;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 4'h0;
			w_data  <= 32'h00000000;
			w_strb  <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= 2'h0;
			s_axi_rdata  <= 32'h00000000;
			control_one_low  <= `RESET_REG16; // RULE_26
			control_one_high <= `RESET_REG16; // RULE_26
			control_two_low  <= `RESET_REG16; // RULE_26
			period_value     <= `RESET_PERIOD;
			one_shot_extension   <= 3'h0;
			capture_input_select <= 3'h0;
		end
		else
		begin
			if (s_axi_awvalid && !aw_held)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_held)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'h0;
				// Unimplemented bits masked so they read zero
				if (aw_addr == `ADDR_CONTROL_ONE_LOW)
					control_one_low <= ((control_one_low & keepmsk) | merged) & `MASK_CONTROL_ONE_LOW; // RULE_26
				else if (aw_addr == `ADDR_CONTROL_ONE_HIGH)
					control_one_high <= ((control_one_high & keepmsk) | merged) & `MASK_CONTROL_ONE_HIGH; // RULE_26
				else if (aw_addr == `ADDR_CONTROL_TWO_LOW)
					control_two_low <= ((control_two_low & keepmsk) | merged) & `MASK_CONTROL_TWO_LOW; // RULE_26
				else if (aw_addr == `ADDR_PERIOD_VALUE)
				begin
					period_value <= (period_value & keepmsk) | merged;
					if (w_strb[2])
					begin
						one_shot_extension   <= w_data[18:16];
						capture_input_select <= w_data[22:20];
					end
				end
				else
					s_axi_bresp <= 2'h2;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (s_axi_arvalid && !s_axi_rvalid)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'h0;
				if (s_axi_araddr == `ADDR_CONTROL_ONE_LOW)
					s_axi_rdata <= {16'h0000, control_one_low};
				else if (s_axi_araddr == `ADDR_CONTROL_ONE_HIGH)
					s_axi_rdata <= {16'h0000, control_one_high};
				else if (s_axi_araddr == `ADDR_CONTROL_TWO_LOW)
					s_axi_rdata <= {15'h0000, shutdown_event_flag, control_two_low};
				else if (s_axi_araddr == `ADDR_PERIOD_VALUE)
					s_axi_rdata <= {9'h000, capture_input_select, 1'b0, one_shot_extension,
						period_value};
				else
				begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'h2;
				end
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	wire in_capture  = capture_vs_compare; // RULE_22
	wire cap_legal   = in_capture & (function_code <= 4'h5); // RULE_03
	wire cmp_single  = ~in_capture & (function_code >= 4'h1) & (function_code <= 4'h3); // RULE_07
	wire cmp_dual    = ~in_capture & (function_code[3:1] == 3'h2); // RULE_06
	wire cmp_center  = ~in_capture & (function_code == 4'h6) & (FULL_VARIANT != 0); // RULE_05
	wire cmp_varfreq = ~in_capture & (function_code == 4'h7); // RULE_05
	wire cmp_extern  = ~in_capture & (function_code == `CODE_EXTERNAL); // RULE_04
	wire cmp_timer   = ~in_capture & (function_code == 4'h0); // RULE_08
	wire sync_legal  = (sync_select <= 5'h05) || (sync_select[4:2] == 3'h2 && sync_select[1:0] != 2'h0)
		|| (sync_select[4:1] == 4'h8) || (sync_select[4:3] == 2'h3 && sync_select[2:0] <= 3'h4)
		|| (sync_select == `SYNC_NONE); // RULE_17
	// Reserved codes stall the timer, the output and the captures
	wire mode_legal  = (cap_legal | cmp_single | cmp_dual | cmp_center | cmp_varfreq
		| cmp_extern | cmp_timer) & sync_legal; // RULE_25

	// ----------------------------------------
	// Sync / trigger and time base
	// ----------------------------------------
	wire sync_in = (sync_select == `SYNC_NONE) ? 1'b0 :
		(sync_select == 5'h00 || sync_select == 5'h01) ? sync_output :
		sync_sources[sync_select]; // RULE_16 RULE_17
	wire [31:0] top = wide_timebase ? 32'hffffffff : {16'h0000, period_value}; // RULE_23 RULE_16
	// A 16-bit timer left above a smaller period still wraps at all ones
	wire        roll = (timer_value == top)
		| (~wide_timebase & (timer_value[15:0] == 16'hffff)); // RULE_16
	reg         armed;
	reg  [2:0]  shots_left;
	wire        gate = shutdown_event_flag & in_capture;
	assign timer_running = mode_legal & (~triggered_timebase_enable | armed) & ~gate; // RULE_13
	wire trigger_ok = triggered_timebase_enable & sync_in & (~armed | retrigger_allow); // RULE_10
	reg  [3:0]  post_count;
	wire        cap_pulse;
	wire        post_event = in_capture ? cap_pulse :
		(postscale_event_source ? (sync_in & triggered_timebase_enable) : (roll & timer_running)); // RULE_09
	// Capture only tolerates up to 1:4 before the buffer overflows
	wire [3:0]  post_limit = in_capture ? {2'h0, irq_postscale[1:0]} : irq_postscale; // RULE_12

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			timer_value <= 32'h00000000;
			armed       <= 1'b0;
			shots_left  <= 3'h0;
			sync_output <= 1'b0;
			post_count  <= 4'h0;
			module_irq  <= 1'b0;
		end
		else
		begin
			sync_output <= alternate_align_output ? alternate_sync : (roll & timer_running); // RULE_15
			module_irq  <= 1'b0;
			if (trigger_ok)
			begin
				armed       <= 1'b1;
				shots_left  <= one_shot_extension; // RULE_24
				timer_value <= 32'h00000000;
			end
			else if (timer_running)
			begin
				if (roll || (!triggered_timebase_enable && sync_in))
				begin
					timer_value <= 32'h00000000;
					if (single_pulse_trigger && triggered_timebase_enable)
					begin
						if (shots_left == 3'h0)
							armed <= 1'b0; // RULE_14
						else
							shots_left <= shots_left - 3'h1; // RULE_24
					end
				end
				else
					timer_value <= timer_value + 32'h00000001;
			end
			if (post_event)
			begin
				if (post_count >= post_limit)
				begin
					post_count <= 4'h0;
					module_irq <= 1'b1; // RULE_11
				end
				else
					post_count <= post_count + 4'h1;
			end
		end
	end

	// ----------------------------------------
	// Capture path
	// ----------------------------------------
	wire cap_src = capture_inputs[capture_input_select];

	edge_prescaler #(
		.CNT_W(4)
	) u_edge (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.function_code (function_code),
		.enable        (cap_legal & sync_legal & ~gate),
		.sig_in        (cap_src),
		.capture_pulse (cap_pulse)
	);

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			capture_event  <= 1'b0;
			captured_value <= 32'h00000000;
		end
		else
		begin
			capture_event <= cap_pulse;
			if (cap_pulse)
				captured_value <= wide_timebase ? timer_value : {16'h0000, timer_value[15:0]}; // RULE_23
		end
	end

	// ----------------------------------------
	// Shutdown and output
	// ----------------------------------------
	// Bits 3 and 4 have no source and are ignored
	wire shut_req = software_force_shutdown
		| (|(shutdown_source_enables & shutdown_inputs & 8'he7)); // RULE_20 RULE_21
	wire match = (timer_value == compare_value) & timer_running;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			shutdown_event_flag <= 1'b0;
			module_output       <= 1'b0;
		end
		else
		begin
			if (shut_req && (!shutdown_wait_for_rollover || roll)) // RULE_19
				shutdown_event_flag <= 1'b1; // RULE_20
			else if (do_write && aw_addr == `ADDR_CONTROL_TWO_LOW && w_strb[2] && !w_data[16])
				shutdown_event_flag <= 1'b0; // RULE_18
			else if (auto_restart_after_shutdown && !shut_req && roll)
				shutdown_event_flag <= 1'b0; // RULE_18
			if (!mode_legal || shutdown_event_flag || cmp_timer || in_capture)
				module_output <= 1'b0; // RULE_08 RULE_25
			else if (cmp_extern)
				module_output <= cap_src; // RULE_04
			else if (cmp_single && match)
			begin
				case (function_code)
					4'h1: module_output <= 1'b1; // RULE_07
					4'h2: module_output <= 1'b0; // RULE_07
					default: module_output <= ~module_output; // RULE_07
				endcase
			end
			else if (cmp_dual || cmp_center || cmp_varfreq)
			begin
				if (roll)
					module_output <= 1'b1; // RULE_06 RULE_05
				else if (match)
					module_output <= 1'b0; // RULE_06 RULE_05
			end
		end
	end
endmodule

/* ccp_ctrl_regs.vh */
`ifndef CCP_CTRL_REGS_VH
`define CCP_CTRL_REGS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_CONTROL_ONE_LOW   4'h0
`define ADDR_CONTROL_ONE_HIGH  4'h4
`define ADDR_CONTROL_TWO_LOW   4'h8
`define ADDR_PERIOD_VALUE      4'hc

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define RESET_REG16            16'h0000
`define MASK_CONTROL_ONE_LOW   16'h003f
`define MASK_CONTROL_ONE_HIGH  16'hcfff
`define MASK_CONTROL_TWO_LOW   16'hd0ff
`define RESET_PERIOD           16'hffff

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FLD_WIDE               5
`define FLD_CAPSEL             4
`define FLD_PSSRC              15
`define FLD_RETRIG             14
`define FLD_TRIGGERED_TIMEBASE_ENABLE             7
`define FLD_SINGLE_PULSE_TRIGGER            6
`define FLD_ALTERNATE_ALIGN_OUTPUT            5
`define FLD_AUTORST            15
`define FLD_GATEMODE           14
`define FLD_SWSHUT             12

// ----------------------------------------
// Codes
// ----------------------------------------
`define SYNC_NONE              5'h1f
`define CODE_EXTERNAL          4'hf
`define OP_SHOT_BITS           3

`endif

/* edge_prescaler.v */
// ----------------------------------------
// Capture edge qualifier
// ----------------------------------------
module edge_prescaler #(
	parameter CNT_W = 4
)(
	input  wire       aclk,
	input  wire       aresetn,
	input  wire [3:0] function_code,
	input  wire       enable,
	input  wire       sig_in,
	output reg        capture_pulse
);
	reg             prev_in;
	reg [CNT_W-1:0] rise_count;
	wire            rise = sig_in & ~prev_in;
	wire            fall = ~sig_in & prev_in;
	reg             next_capture;

	always @*
	begin
		next_capture = 1'b0;
		if (enable)
		begin
			case (function_code)
				4'h0: next_capture = rise | fall; // RULE_03
				4'h1: next_capture = rise; // RULE_01
				4'h2: next_capture = fall; // RULE_01
				4'h3: next_capture = rise | fall; // RULE_01
				4'h4: next_capture = rise & (rise_count[1:0] == 2'h3); // RULE_02
				4'h5: next_capture = rise & (rise_count == {CNT_W{1'b1}}); // RULE_02
				default: next_capture = 1'b0; // RULE_03 RULE_25
			endcase
		end
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			prev_in       <= 1'b0;
			rise_count    <= {CNT_W{1'b0}};
			capture_pulse <= 1'b0;
		end
		else
		begin
			prev_in       <= sig_in;
			capture_pulse <= next_capture;
			if (!enable)
				rise_count <= {CNT_W{1'b0}};
			else if (rise)
				rise_count <= rise_count + 1'b1;
		end
	end
endmodule

/* ccp_checker_assertions.sv */
module ccp_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        capture_event,
	input wire logic        module_irq,
	input wire logic        shutdown_event_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ------
	// Bus answers
	// ------
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken during answer");
	read_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer not released");
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	write_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer not released");
	resp_code_a: assert property ((s_axi_bvalid -> !s_axi_bresp[0])
		&& (s_axi_rvalid -> !s_axi_rresp[0]))
		else $error("illegal response code");
	error_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
		else $error("error read with data");
	// Must also hold inside reset, so the default disable is overridden
	reset_clear_a: assert property (disable iff (1'h0) !aresetn |=>
		!s_axi_bvalid && !s_axi_rvalid && !capture_event && !module_irq && !shutdown_event_flag)
		else $error("outputs not cleared by reset");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
	cover property (capture_event);
	cover property ($rose(shutdown_event_flag));
endmodule

bind capture_compare_mode_sync_shutdown ccp_checker i_chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.capture_event(capture_event), .module_irq(module_irq),
	.shutdown_event_flag(shutdown_event_flag)
);

/* tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk;
	logic        aresetn;
	logic [3:0]  s_axi_awaddr;
	logic        s_axi_awvalid;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_wvalid;
	logic        s_axi_bready;
	logic [3:0]  s_axi_araddr;
	logic        s_axi_arvalid;
	logic        s_axi_rready;
	logic [7:0]  capture_inputs;
	logic [7:0]  shutdown_inputs;
	logic        alternate_sync;
	logic [31:0] compare_value;
	logic [31:0] sync_sources;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata, captured_value, timer_value;
	wire         module_output, capture_event, sync_output, module_irq;
	wire         shutdown_event_flag, timer_running;
	int          n_fail = 0;
	int          comparisons = 0;
	int          cycles = 0;
	int          n_cap = 0;
	int          n_irq = 0;
	logic [31:0] rd;
	logic [1:0]  rs;
	logic [1:0]  bs;
	capture_compare_mode_sync_shutdown #(.FULL_VARIANT(1)) i_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .sync_sources(sync_sources), .capture_inputs(capture_inputs),
		.shutdown_inputs(shutdown_inputs), .alternate_sync(alternate_sync),
		.compare_value(compare_value), .module_output(module_output),
		.capture_event(capture_event), .captured_value(captured_value),
		.sync_output(sync_output), .module_irq(module_irq),
		.shutdown_event_flag(shutdown_event_flag), .timer_value(timer_value),
		.timer_running(timer_running)
	);
	// ------
	// Clock, timeout, event counters
	// ------
	initial
	begin
		aclk = 1'h0;
		forever #20 aclk = ~aclk;
	end
	always @(posedge aclk)
	begin
		cycles <= cycles + 1;
		n_cap <= n_cap + (capture_event === 1'h1);
		n_irq <= n_irq + (module_irq === 1'h1);
		if (cycles == 20000)
		begin
			n_fail = n_fail + 1;
			stop_test();
		end
	end
	// ------
	// Shared tasks
	// ------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Address and data offered together, each released once taken
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		bit aw_ok;
		bit w_ok;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		aw_ok = 0;
		w_ok = 0;
		forever
		begin
			@(posedge aclk);
			if (aw_ok && w_ok && s_axi_bvalid === 1'h1)
			begin
				bs = s_axi_bresp;
				s_axi_bready <= 1'h0;
				break;
			end
			if (s_axi_awready === 1'h1)
			begin
				s_axi_awvalid <= 1'h0;
				aw_ok = 1;
			end
			if (s_axi_wready === 1'h1)
			begin
				s_axi_wvalid <= 1'h0;
				w_ok = 1;
			end
		end
	endtask
	task automatic rdr(input logic [3:0] a);
		bit ar_ok;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		ar_ok = 0;
		forever
		begin
			@(posedge aclk);
			if (ar_ok && s_axi_rvalid === 1'h1)
			begin
				rd = s_axi_rdata;
				rs = s_axi_rresp;
				s_axi_rready <= 1'h0;
				break;
			end
			if (s_axi_arready === 1'h1)
			begin
				s_axi_arvalid <= 1'h0;
				ar_ok = 1;
			end
		end
	endtask
	task automatic pulse(input int b);
		cyc(3);
		capture_inputs[b] <= 1'h1;
		cyc(3);
		capture_inputs[b] <= 1'h0;
	endtask
	// ------
	// Scenarios
	// ------
	task automatic t_regs;
		logic [31:0] rst [4] = '{32'h0, 32'h0, 32'h0, 32'hffff};
		logic [31:0] msk [3] = '{32'h3f, 32'hcfff, 32'hc0ff};
		for (int i = 0; i < 4; i++)
		begin
			rdr(4'(i * 4));
			check("reset value", rst[i], rd);
		end
		// Bit 12 of the third register left out: it would force a shutdown
		for (int i = 0; i < 3; i++)
		begin
			wr(4'(i * 4), 32'hefff, 4'h3);
			rdr(4'(i * 4));
			check("write mask", msk[i], rd);
			wr(4'(i * 4), 32'h0, 4'h3);
		end
		rdr(4'h2);
		check("unmapped response", 32'h2, {30'h0, rs});
		check("unmapped data", 32'h0, rd);
		wr(4'h2, 32'hffff, 4'h3);
		check("unmapped write response", 32'h2, {30'h0, bs});
		$display("register test done");
	endtask
	task automatic t_capture;
		logic [3:0] code [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8};
		int         want [8] = '{32, 16, 16, 32, 4, 1, 0, 0};
		int         base;
		for (int i = 0; i < 10; i++)
		begin
			wr(4'h4, (i < 9) ? {23'h0, i == 8, 8'h0} : 32'hf00, 4'h3);
			wr(4'h0, {28'h1, (i < 8) ? code[i] : 4'h1}, 4'h3);
			base = (i < 8) ? n_cap : n_irq;
			repeat (16) pulse(0);
			cyc(6);
			if (i < 8)
				check("captures", want[i], n_cap - base);
			else
				check("capture irqs", (i == 8) ? 8 : 4, n_irq - base);
		end
		check("capture width", 32'h0, {16'h0, captured_value[31:16]});
		wr(4'h4, 32'h0, 4'h3);
		$display("capture test done");
	endtask
	task automatic t_compare;
		logic [31:0] mx;
		int          ns;
		int          nt;
		logic        last;
		wr(4'hc, 32'h14, 4'hf);
		// Own sync held high clears the timer left running above the new period
		alternate_sync <= 1'h1;
		wr(4'h4, 32'h20, 4'h3);
		wr(4'h4, 32'h1f, 4'h3);
		alternate_sync <= 1'h0;
		compare_value <= 32'h5;
		wr(4'h0, 32'h0, 4'h3);
		mx = 0;
		ns = 0;
		repeat (105)
		begin
			@(posedge aclk);
			mx = (timer_value > mx) ? timer_value : mx;
			ns += (sync_output === 1'h1);
		end
		check("timer top", 32'h14, mx);
		check("sync pulses", 1, ns >= 4 && ns <= 5);
		check("timer mode output", 1'h0, module_output);
		wr(4'h0, 32'h1, 4'h3);
		cyc(30);
		check("set on match", 1'h1, module_output);
		wr(4'h0, 32'h2, 4'h3);
		cyc(30);
		check("clear on match", 1'h0, module_output);
		wr(4'h0, 32'h3, 4'h3);
		nt = 0;
		last = module_output;
		repeat (105)
		begin
			@(posedge aclk);
			nt += (module_output !== last);
			last = module_output;
		end
		check("toggles", 1, nt >= 4 && nt <= 6);
		wr(4'h0, 32'he, 4'h3);
		cyc(3);
		mx = timer_value;
		cyc(10);
		check("reserved halts timer", mx, timer_value);
		wr(4'hc, 32'h300014, 4'hf);
		wr(4'h0, 32'hf, 4'h3);
		capture_inputs[3] <= 1'h1;
		cyc(4);
		check("external high", 1'h1, module_output);
		capture_inputs[3] <= 1'h0;
		cyc(4);
		check("external low", 1'h0, module_output);
		wr(4'h4, 32'h3f, 4'h3);
		alternate_sync <= 1'h1;
		cyc(4);
		check("alternate sync", 1'h1, sync_output);
		alternate_sync <= 1'h0;
		wr(4'h4, 32'h0, 4'h3);
		wr(4'h0, 32'h0, 4'h3);
		$display("compare test done");
	endtask
	task automatic t_shutdown;
		wr(4'h8, 32'h40, 4'h3);
		shutdown_inputs <= 8'h40;
		cyc(4);
		check("fault a shutdown", 1'h1, shutdown_event_flag);
		shutdown_inputs <= 8'h0;
		cyc(30);
		check("flag held", 1'h1, shutdown_event_flag);
		wr(4'h8, 32'h0, 4'h4);
		rdr(4'h8);
		check("flag cleared", 32'h40, rd);
		wr(4'h8, 32'h18, 4'h3);
		shutdown_inputs <= 8'h18;
		cyc(6);
		check("unused sources", 1'h0, shutdown_event_flag);
		shutdown_inputs <= 8'h0;
		wr(4'h8, 32'h1000, 4'h3);
		rdr(4'h8);
		check("software shutdown", 32'h11000, rd);
		wr(4'h8, 32'h8001, 4'h3);
		wr(4'h8, 32'h0, 4'h4);
		shutdown_inputs <= 8'h1;
		cyc(4);
		check("source 0 shutdown", 1'h1, shutdown_event_flag);
		shutdown_inputs <= 8'h0;
		cyc(30);
		check("auto restart", 1'h0, shutdown_event_flag);
		// Timer held at zero, so no rollover until the hold is lifted
		alternate_sync <= 1'h1;
		wr(4'h4, 32'h20, 4'h3);
		wr(4'h8, 32'h4001, 4'h3);
		shutdown_inputs <= 8'h1;
		cyc(6);
		check("gated shutdown waits", 1'h0, shutdown_event_flag);
		alternate_sync <= 1'h0;
		cyc(30);
		check("gated shutdown at roll", 1'h1, shutdown_event_flag);
		shutdown_inputs <= 8'h0;
		wr(4'h8, 32'h0, 4'hf);
		$display("shutdown test done");
	endtask
	task automatic t_trigger;
		wr(4'h4, 32'hc9, 4'h3);
		cyc(3);
		check("waits for trigger", 1'h0, timer_running);
		sync_sources[9] <= 1'h1;
		cyc(1);
		sync_sources[9] <= 1'h0;
		cyc(2);
		check("trigger starts", 1'h1, timer_running);
		cyc(30);
		check("one shot stops", 1'h0, timer_running);
		wr(4'h4, 32'h0, 4'h3);
		$display("trigger test done");
	endtask
	initial
	begin
		aresetn = 1'h0;
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{capture_inputs, shutdown_inputs, alternate_sync, compare_value, sync_sources} = '0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		t_regs();
		t_capture();
		t_compare();
		t_shutdown();
		t_trigger();
		stop_test();
	end
endmodule
